// ==== inc/ais_regs.svh ====
`ifndef AIS_REGS_SVH
`define AIS_REGS_SVH

// Register byte offsets
`define AIS_OFF_CTRL      12'h000
`define AIS_OFF_FAULT     12'h004
`define AIS_OFF_RANGE     12'h008
`define AIS_OFF_CFG_BASE  12'h010
`define AIS_OFF_VAL_BASE  12'h040

// Field positions
`define AIS_CTRL_LEGACY   0
`define AIS_FAULT_CFG     8
`define AIS_FAULT_ADC     9
`define AIS_FAULT_CAL     10
`define AIS_CFG_MODE_LSB  0
`define AIS_CFG_FILT_LSB  4

// Reset values
`define AIS_CTRL_RST      1'b0
`define AIS_CFG_RST       5'h00

// Timing
`define AIS_CLK_MHZ       125
`define AIS_SCAN_US       680
`define AIS_HOLD_S        10
`define AIS_NUM_CH        8

// Limits, in the units of each mode
`define AIS_CUR_LIM       32'sd20002
`define AIS_RLO_LIM       32'sd25187
`define AIS_RHI_LIM       32'sd302010
`define AIS_PT_MIN        (-32'sd500)
`define AIS_PT_MAX        32'sd4087
`define AIS_NI_MIN        (-32'sd500)
`define AIS_NI_MAX        32'sd2103
`define AIS_NILS_MIN      (-32'sd300)
`define AIS_NILS_MAX      32'sd1300
`define AIS_DIODE_MAX     32'sd4999
`define AIS_TRIP_UA       32'sd30000
`define AIS_TRIP_OLD_UA   32'sd24000

`endif

// ==== inc/ais_pkg.sv ====
package ais_pkg;

   typedef enum logic [2:0] {
      AIS_MODE_VOLT  = 3'h0,
      AIS_MODE_CUR   = 3'h1,
      AIS_MODE_RLO   = 3'h2,
      AIS_MODE_RHI   = 3'h3,
      AIS_MODE_PT    = 3'h4,
      AIS_MODE_NI    = 3'h5,
      AIS_MODE_NILS  = 3'h6,
      AIS_MODE_DIODE = 3'h7
   } ais_mode_t;

   typedef enum logic [1:0] {
      AIS_FILT_OFF = 2'h0,
      AIS_FILT_4   = 2'h1,
      AIS_FILT_8   = 2'h2,
      AIS_FILT_16  = 2'h3
   } ais_filt_t;

   typedef struct packed {
      ais_filt_t filt;
      ais_mode_t mode;
   } ais_chcfg_t;

   typedef struct packed {
      logic [2:0]         chan;
      logic signed [31:0] value;
   } ais_sample_t;

   typedef enum logic [1:0] {
      AIS_ST_IDLE  = 2'b00,
      AIS_ST_START = 2'b01,
      AIS_ST_WAIT  = 2'b11,
      AIS_ST_STORE = 2'b10
   } ais_state_t;

endpackage : ais_pkg

// ==== rtl/ais_filter.sv ====
`timescale 1ns/1ps
`include "ais_regs.svh"
module ais_filter
   import ais_pkg::*;
#(
   parameter int NCH = `AIS_NUM_CH
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              in_valid,
   input  wire ais_sample_t       in_smp,
   input  wire ais_filt_t         in_filt,
   input  wire logic [NCH-1:0]    restart,
   output logic                   out_valid,
   output ais_sample_t            out_smp
);

   logic signed [35:0] acc [NCH];
   logic [3:0]         cnt [NCH];
   logic signed [35:0] sum;

   function automatic logic [3:0] last_idx(input ais_filt_t f);
      case (f)
         AIS_FILT_4:  last_idx = 4'h3;
         AIS_FILT_8:  last_idx = 4'h7;
         AIS_FILT_16: last_idx = 4'hf;
         default:     last_idx = 4'h0;
      endcase
   endfunction : last_idx

   function automatic logic [2:0] shift(input ais_filt_t f);
      case (f)
         AIS_FILT_4:  shift = 3'h2;
         AIS_FILT_8:  shift = 3'h3;
         AIS_FILT_16: shift = 3'h4;
         default:     shift = 3'h0;
      endcase
   endfunction : shift

   assign sum = acc[in_smp.chan] + 36'(in_smp.value);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NCH; i++) begin
            acc[i] <= '0;
            cnt[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (restart[i]) begin
               acc[i] <= '0;
               cnt[i] <= '0;
            end else if (in_valid && in_smp.chan == 3'(i)
                         && in_filt != AIS_FILT_OFF) begin
               if (cnt[i] == last_idx(in_filt)) begin
                  acc[i] <= '0;
                  cnt[i] <= '0;
               end else begin
                  acc[i] <= sum;
                  cnt[i] <= cnt[i] + 4'h1;
               end
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_smp   <= '0;
      end else begin
         out_valid <= 1'b0;
         if (in_valid && !restart[in_smp.chan]) begin
            if (in_filt == AIS_FILT_OFF) begin
               out_valid <= 1'b1;
               out_smp   <= in_smp;
            end else if (cnt[in_smp.chan] == last_idx(in_filt)) begin
               // Power-of-two window: mean is an arithmetic shift
               out_valid     <= 1'b1;
               out_smp.chan  <= in_smp.chan;
               out_smp.value <= 32'(sum >>> shift(in_filt));
            end
         end
      end
   end

endmodule : ais_filter

// ==== rtl/ais_protect.sv ====
`timescale 1ns/1ps
`include "ais_regs.svh"
module ais_protect #(
   parameter int          NCH  = `AIS_NUM_CH,
   parameter int unsigned HOLD = `AIS_HOLD_S * `AIS_CLK_MHZ * 1000000
) (
   input  wire logic           pclk,
   input  wire logic           presetn,
   input  wire logic           trip,
   input  wire logic [2:0]     trip_chan,
   input  wire logic           legacy,
   output logic [NCH-1:0]      prot
);

   logic [31:0] hold_cnt [NCH];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prot <= '0;
         for (int i = 0; i < NCH; i++) begin
            hold_cnt[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (trip && trip_chan == 3'(i) && !prot[i]) begin
               prot[i]     <= 1'b1;
               hold_cnt[i] <= HOLD - 32'd1;
            end else if (prot[i] && !legacy) begin
               if (hold_cnt[i] == 32'd0) begin
                  prot[i] <= 1'b0;
               end else begin
                  hold_cnt[i] <= hold_cnt[i] - 32'd1;
               end
            end
         end
      end
   end

endmodule : ais_protect

// ==== rtl/ais_scanner.sv ====
// Function
// - Convert channels one by one, ascending, wrapping, one full scan per 680 us.
// - Each channel chooses its own filter: off, or mean of 4, 8, 16.
// - Filter off: buffer entry rewritten with each new result, once per scan.
// - Filter on: store mean of 4, 8 or 16 results, once per window.
// - Per-channel out-of-range flags readable in their own status register.
// - Range limits for current and both resistance ranges; voltage never flags.
// - Range limits for platinum, nickel and alternative nickel temperature modes.
// - Diode mode reports millivolts with the resistance input stage.
// - Current above 30 mA opens the shunt; older revisions use 24 mA.
// - Fault register bit of a channel is one while its protection is engaged.
// - Protection changes the input stage switches with no software action.
// - Newer revisions hold protection for 10 s, then restore normal stage.
// - Overload still present after restore triggers protection and a new hold.
// - Oldest revisions keep protection until the controller restarts.
// - One error output summarises every module error; cause read from status.
// - Errors: config not applied, converter silent, no calibration, protection.
// - Acquisition free-runs, overwriting one latest value per channel.
// - Buffered values leave the block only as answers to bus reads.
// - Values and per-channel configuration are readable through registers.
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "ais_regs.svh"
module ais_scanner
   import ais_pkg::*;
#(
   parameter int          NCH  = `AIS_NUM_CH,
   parameter int unsigned SLOT =
      (`AIS_SCAN_US * `AIS_CLK_MHZ) / `AIS_NUM_CH,
   parameter int unsigned HOLD = `AIS_HOLD_S * `AIS_CLK_MHZ * 1000000
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   output logic                    adc_start,
   output logic [2:0]              adc_chan,
   input  wire logic               adc_done,
   input  wire logic signed [31:0] adc_data,
   output ais_mode_t [NCH-1:0]     stage_mode,
   output logic [NCH-1:0]          shunt_open,
   input  wire logic               cfg_fault_pin,
   input  wire logic               cal_missing_pin,
   output logic                    fault_led
);

   ais_state_t         state;
   logic [31:0]        slot_cnt;
   logic               slot_tick;
   logic [2:0]         chan;
   logic               smp_valid;
   ais_sample_t        smp;
   logic               trip;
   logic               store_valid;
   ais_sample_t        store_smp;
   logic               legacy;
   ais_chcfg_t         cfg [NCH];
   logic signed [31:0] value_buf [NCH];
   logic [NCH-1:0]     range_violation_flags;
   logic [NCH-1:0]     prot;
   logic [NCH-1:0]     restart;
   logic               adc_err;
   logic [2:0]         cfg_sync;
   logic [2:0]         cal_sync;
   logic               cfg_err;
   logic               cal_err;
   logic [31:0]        fault_flags;
   logic               wr_en;
   logic               rd_setup;
   ais_chcfg_t         wr_cfg;
   logic [31:0]        next_prdata;
   logic               next_pslverr;

   function automatic logic range_bad(input ais_mode_t m,
                                      input logic signed [31:0] v);
      case (m)
         AIS_MODE_VOLT:  range_bad = 1'b0;
         AIS_MODE_CUR:   range_bad = v > `AIS_CUR_LIM ||
                                     v < -`AIS_CUR_LIM;
         AIS_MODE_RLO:   range_bad = v > `AIS_RLO_LIM;
         AIS_MODE_RHI:   range_bad = v > `AIS_RHI_LIM;
         AIS_MODE_PT:    range_bad = v < `AIS_PT_MIN ||
                                     v > `AIS_PT_MAX;
         AIS_MODE_NI:    range_bad = v < `AIS_NI_MIN ||
                                     v > `AIS_NI_MAX;
         AIS_MODE_NILS:  range_bad = v < `AIS_NILS_MIN ||
                                     v > `AIS_NILS_MAX;
         AIS_MODE_DIODE: range_bad = v > `AIS_DIODE_MAX;
         default:        range_bad = 1'b0;
      endcase
   endfunction : range_bad

   function automatic logic [3:0] reg_index(input logic [11:0] a,
                                            input logic [11:0] base);
      logic [11:0] d;
      d = a - base;
      reg_index = {1'b0, d[4:2]};
      if (a < base || d > 12'h01c || d[1:0] != 2'b00) begin
         reg_index = 4'h8;
      end
   endfunction : reg_index

   // Slot timer runs whatever the bus does, so the scan rate is fixed
   assign slot_tick = (slot_cnt == SLOT - 32'd1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_cnt <= '0;
      end else if (slot_tick) begin
         slot_cnt <= '0;
      end else begin
         slot_cnt <= slot_cnt + 32'd1;
      end
   end

   // Converter sits on this clock, so its strobes need no synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= AIS_ST_IDLE;
         chan      <= '0;
         adc_start <= 1'b0;
         adc_chan  <= '0;
         smp_valid <= 1'b0;
         smp       <= '0;
         adc_err   <= 1'b0;
      end else begin
         adc_start <= 1'b0;
         smp_valid <= 1'b0;
         case (state)
            AIS_ST_IDLE: begin
               if (slot_tick) begin
                  state <= AIS_ST_START;
               end
            end
            AIS_ST_START: begin
               adc_start <= 1'b1;
               adc_chan  <= chan;
               state     <= AIS_ST_WAIT;
            end
            AIS_ST_WAIT: begin
               if (adc_done) begin
                  adc_err   <= 1'b0;
                  smp_valid <= 1'b1;
                  smp.chan  <= chan;
                  smp.value <= adc_data;
                  state     <= AIS_ST_STORE;
               end else if (slot_tick) begin
                  // Silent converter: skip to next slot, keep old value
                  adc_err <= 1'b1;
                  chan    <= chan + 3'h1;
                  state   <= AIS_ST_START;
               end
            end
            AIS_ST_STORE: begin
               chan  <= chan + 3'h1;
               state <= AIS_ST_IDLE;
            end
            default: begin
               state <= AIS_ST_IDLE;
            end
         endcase
      end
   end

   // Trip on the raw result: a filtered mean would react far too late
   assign trip = smp_valid && cfg[smp.chan].mode == AIS_MODE_CUR &&
                 !prot[smp.chan] &&
                 ((legacy && (smp.value > `AIS_TRIP_OLD_UA ||
                              smp.value < -`AIS_TRIP_OLD_UA)) ||
                  (!legacy && (smp.value > `AIS_TRIP_UA ||
                               smp.value < -`AIS_TRIP_UA)));

   ais_filter #(
      .NCH       (NCH)
   ) u_filter (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (smp_valid),
      .in_smp    (smp),
      .in_filt   (cfg[smp.chan].filt),
      .restart   (restart),
      .out_valid (store_valid),
      .out_smp   (store_smp)
   );

   ais_protect #(
      .NCH       (NCH),
      .HOLD      (HOLD)
   ) u_protect (
      .pclk      (pclk),
      .presetn   (presetn),
      .trip      (trip),
      .trip_chan (smp.chan),
      .legacy    (legacy),
      .prot      (prot)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NCH; i++) begin
            value_buf[i] <= '0;
         end
         range_violation_flags <= '0;
      end else if (store_valid) begin
         value_buf[store_smp.chan] <= store_smp.value;
         range_violation_flags[store_smp.chan] <=
            range_bad(cfg[store_smp.chan].mode, store_smp.value);
      end
   end

   // Stage switches follow the mode; protection overrides the shunt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_mode <= '0;
         shunt_open <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            stage_mode[i] <= cfg[i].mode;
            shunt_open[i] <= prot[i] ||
                             cfg[i].mode != AIS_MODE_CUR;
         end
      end
   end

   // Status pins: 3 flops, a level counts once stages 2 and 3 agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_sync <= '0;
         cal_sync <= '0;
         cfg_err  <= 1'b0;
         cal_err  <= 1'b0;
      end else begin
         cfg_sync <= {cfg_sync[1:0], cfg_fault_pin};
         cal_sync <= {cal_sync[1:0], cal_missing_pin};
         if (cfg_sync[1] == cfg_sync[2]) begin
            cfg_err <= cfg_sync[2];
         end
         if (cal_sync[1] == cal_sync[2]) begin
            cal_err <= cal_sync[2];
         end
      end
   end

   always_comb begin
      fault_flags = '0;
      fault_flags[NCH-1:0]       = prot;
      fault_flags[`AIS_FAULT_CFG] = cfg_err;
      fault_flags[`AIS_FAULT_ADC] = adc_err;
      fault_flags[`AIS_FAULT_CAL] = cal_err;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_led <= 1'b0;
      end else begin
         fault_led <= |fault_flags;
      end
   end

   // APB: zero wait states, read data prepared in the setup cycle
   assign pready   = 1'b1;
   assign wr_en    = psel && penable && pwrite;
   assign rd_setup = psel && !penable;
   assign wr_cfg   = ais_chcfg_t'({pwdata[`AIS_CFG_FILT_LSB +: 2],
                                   pwdata[`AIS_CFG_MODE_LSB +: 3]});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         legacy <= `AIS_CTRL_RST;
         for (int i = 0; i < NCH; i++) begin
            cfg[i] <= ais_chcfg_t'(`AIS_CFG_RST);
         end
         restart <= '0;
      end else begin
         restart <= '0;
         if (wr_en && paddr == `AIS_OFF_CTRL) begin
            legacy <= pwdata[`AIS_CTRL_LEGACY];
         end
         for (int i = 0; i < NCH; i++) begin
            if (wr_en && reg_index(paddr, `AIS_OFF_CFG_BASE) == 4'(i))
            begin
               cfg[i] <= wr_cfg;
               if (wr_cfg != cfg[i]) begin
                  restart[i] <= 1'b1;
               end
            end
         end
      end
   end

   always_comb begin
      logic [3:0] ci;
      logic [3:0] vi;
      ci = reg_index(paddr, `AIS_OFF_CFG_BASE);
      vi = reg_index(paddr, `AIS_OFF_VAL_BASE);
      next_prdata  = '0;
      next_pslverr = 1'b0;
      if (paddr == `AIS_OFF_CTRL) begin
         next_prdata[`AIS_CTRL_LEGACY] = legacy;
      end else if (paddr == `AIS_OFF_FAULT) begin
         next_prdata = fault_flags;
      end else if (paddr == `AIS_OFF_RANGE) begin
         next_prdata[NCH-1:0] = range_violation_flags;
      end else if (ci < 4'h8) begin
         next_prdata[`AIS_CFG_FILT_LSB +: 2] = cfg[ci[2:0]].filt;
         next_prdata[`AIS_CFG_MODE_LSB +: 3] = cfg[ci[2:0]].mode;
      end else if (vi < 4'h8) begin
         next_prdata = value_buf[vi[2:0]];
      end else begin
         next_pslverr = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (rd_setup) begin
         prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
         pslverr <= next_pslverr;
      end else if (!psel) begin
         pslverr <= 1'b0;
      end
   end

endmodule : ais_scanner

// ==== verification/ais_scanner_sva.sv ====
`timescale 1ns/1ps
module ais_sva
   import ais_pkg::*;
#(
   parameter int NCH  = 8,
   parameter int SLOT = 40
) (
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [11:0]         paddr,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire logic                adc_start,
   input wire logic [2:0]          adc_chan,
   input wire logic                adc_done,
   input wire logic signed [31:0]  adc_data,
   input wire ais_mode_t [NCH-1:0] stage_mode,
   input wire logic [NCH-1:0]      shunt_open,
   input wire logic                cfg_fault_pin,
   input wire logic                fault_led
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       seen;
   logic       got;
   logic       ok;
   logic [2:0] last;
   int         gap;
   logic       trip;
   assign trip = adc_done && stage_mode[adc_chan] == AIS_MODE_CUR &&
                 adc_data > 32'sh7530;
   // Spacing is judged after two answered slots; a silent one keeps the same phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen <= 1'b0;
         got  <= 1'b0;
         ok   <= 1'b0;
         last <= 3'h0;
         gap  <= 0;
      end else begin
         gap  <= adc_start ? 1 : gap + 1;
         got  <= adc_start ? 1'b0 : (got | adc_done);
         seen <= seen | adc_start;
         if (adc_start) begin
            last <= adc_chan;
            ok   <= got;
         end
      end
   end
   AST_START_PULSE: assert property (adc_start |=> !adc_start)
      else $error("converter start longer than one cycle");
   AST_CHAN_ORDER: assert property (
      adc_start && seen |-> adc_chan == last + 3'h1)
      else $error("channel order broken");
   AST_SLOT_RATE: assert property (
      adc_start && seen && got && ok |-> gap == SLOT)
      else $error("slot spacing wrong");
   AST_TRIP_SHUNT: assert property (
      trip |-> ##[1:4] shunt_open[adc_chan])
      else $error("overcurrent did not open shunt");
   AST_TRIP_LED: assert property (trip |-> ##[2:6] fault_led)
      else $error("protection not shown on indicator");
   AST_NONCUR_SHUNT: assert property (
      stage_mode[0] != AIS_MODE_CUR ##1 stage_mode[0] != AIS_MODE_CUR
      |=> shunt_open[0])
      else $error("shunt closed outside current mode");
   AST_READY: assert property (psel && penable |-> pready)
      else $error("bus access not answered");
   AST_WR_ZERO: assert property (
      psel && penable && pwrite |-> !prdata)
      else $error("read data not zero on write");
   AST_UNMAPPED: assert property (
      psel && !penable && paddr == 12'hffc |=> pslverr && !prdata)
      else $error("unmapped access not refused");
   AST_PIN_LED: assert property (
      $rose(cfg_fault_pin) |-> ##[3:8] fault_led)
      else $error("config fault not shown");
endmodule : ais_sva

bind ais_scanner ais_sva #(.NCH(NCH), .SLOT(SLOT)) chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .adc_start(adc_start), .adc_chan(adc_chan),
   .adc_done(adc_done), .adc_data(adc_data), .stage_mode(stage_mode),
   .shunt_open(shunt_open), .cfg_fault_pin(cfg_fault_pin),
   .fault_led(fault_led));

// ==== verification/ais_adc_model.sv ====
`timescale 1ns/1ps
module ais_adc_model (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          adc_start,
   input  wire logic [2:0]    adc_chan,
   output logic               adc_done,
   output logic signed [31:0] adc_data
);
   logic signed [31:0] val [8] = '{default: 32'sh0};
   int                 lat = 2;
   logic               silent = 1'b0;
   int                 cnt;
   // Data line toggles between results so a stale value never passes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt      <= 0;
         adc_done <= 1'b0;
         adc_data <= 32'sh0;
      end else begin
         adc_done <= 1'b0;
         adc_data <= ~adc_data;
         if (adc_start && !silent)
            cnt <= lat;
         else if (cnt > 0)
            cnt <= cnt - 1;
         if (cnt == 1) begin
            adc_done <= 1'b1;
            adc_data <= val[adc_chan];
         end
      end
   end
endmodule : ais_adc_model

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
   compares++; \
   if ((s) !== (e)) begin \
      errors++; \
      $display("[FAIL] %s exp %h got %h", n, e, s); \
   end \
end
module tb;
   import ais_pkg::*;
   typedef struct {
      ais_mode_t          m;
      logic signed [31:0] d;
      logic               r;
   } ais_row_t;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0]       paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic              adc_start, adc_done, cfg_pin, cal_pin, fault_led, err;
   logic [2:0]        adc_chan;
   logic signed [31:0] adc_data;
   ais_mode_t [7:0]   stage_mode;
   logic [7:0]        shunt_open;
   int                errors = 0;
   int                compares = 0;
   ais_row_t rows [8] = '{
      '{AIS_MODE_VOLT,  32'sh4e20,  1'b0},
      '{AIS_MODE_CUR,   32'sh4e23,  1'b1},
      '{AIS_MODE_RLO,   32'sh6264,  1'b1},
      '{AIS_MODE_RHI,   32'sh49bba, 1'b0},
      '{AIS_MODE_PT,    -32'sh1f5,  1'b1},
      '{AIS_MODE_NI,    32'sh837,   1'b0},
      '{AIS_MODE_NILS,  32'sh515,   1'b1},
      '{AIS_MODE_DIODE, 32'sh1387,  1'b0}};
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   ais_scanner #(.NCH(8), .SLOT(40), .HOLD(200)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .adc_start(adc_start),
      .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data),
      .stage_mode(stage_mode), .shunt_open(shunt_open),
      .cfg_fault_pin(cfg_pin), .cal_missing_pin(cal_pin),
      .fault_led(fault_led));
   ais_adc_model adc (
      .pclk(pclk), .presetn(presetn), .adc_start(adc_start),
      .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data));
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic scans(input int n);
      repeat (n * 320) @(posedge pclk);
   endtask : scans
   // Bounded wait for channel 1 shunt to reach a level
   task automatic wait_sh(input logic v);
      int n;
      n = 0;
      while (shunt_open[1] !== v && n < 400) begin
         @(posedge pclk);
         n++;
      end
      `CHK("shunt1", v, shunt_open[1])
   endtask : wait_sh
   task automatic end_of_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (60000) @(posedge pclk);
      errors++;
      end_of_test();
   end
   initial begin
      {psel, penable, pwrite, cfg_pin, cal_pin, presetn} = 6'h0;
      paddr  = 12'h0;
      pwdata = 32'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         adc.val[i] <= rows[i].d;
         apb(1'b1, 12'h010 + 12'(i * 4), {29'h0, rows[i].m});
      end
      scans(3);
      foreach (rows[i]) begin
         apb(1'b0, 12'h040 + 12'(i * 4), 32'h0);
         `CHK("value", rows[i].d, rd)
         `CHK("stage", rows[i].m, stage_mode[i])
      end
      apb(1'b0, 12'h008, 32'h0);
      foreach (rows[i]) `CHK("range", rows[i].r, rd[i])
      $display("test table done");
      adc.lat <= 20;
      for (int f = 0; f < 4; f++) begin
         // New level lands before the last restart, so no stale sample mixes in
         if (f == 3) adc.val[0] <= 32'sh1f4;
         apb(1'b1, 12'h010, {26'h0, 2'(f), 4'h0});
         apb(1'b0, 12'h010, 32'h0);
         `CHK("cfg0", {2'(f), 4'h0}, rd[5:0])
      end
      scans(2);
      apb(1'b0, 12'h040, 32'h0);
      `CHK("mean16 early", 32'h4e20, rd)
      scans(15);
      apb(1'b0, 12'h040, 32'h0);
      `CHK("mean16", 32'h1f4, rd)
      $display("test filter done");
      adc.val[1] <= 32'sh7531;
      wait_sh(1'b1);
      apb(1'b0, 12'h004, 32'h0);
      `CHK("fault prot", 1'b1, rd[1])
      `CHK("led", 1'b1, fault_led)
      wait_sh(1'b0);
      wait_sh(1'b1);
      adc.val[1] <= 32'sh0;
      scans(2);
      `CHK("released", 1'b0, shunt_open[1])
      apb(1'b0, 12'h008, 32'h0);
      `CHK("range clear", 1'b0, rd[1])
      apb(1'b0, 12'h044, 32'h0);
      `CHK("value1", 32'h0, rd)
      apb(1'b1, 12'h000, 32'h1);
      adc.val[1] <= 32'sh7531;
      wait_sh(1'b1);
      adc.val[1] <= 32'sh0;
      scans(2);
      `CHK("legacy hold", 1'b1, shunt_open[1])
      $display("test protection done");
      adc.silent <= 1'b1;
      scans(1);
      apb(1'b0, 12'h004, 32'h0);
      `CHK("adc err", 1'b1, rd[9])
      adc.silent <= 1'b0;
      cfg_pin <= 1'b1;
      cal_pin <= 1'b1;
      scans(1);
      apb(1'b0, 12'h004, 32'h0);
      `CHK("pin errs", 3'h5, rd[10:8])
      cfg_pin <= 1'b0;
      cal_pin <= 1'b0;
      apb(1'b0, 12'hffc, 32'h0);
      `CHK("unmapped", 1'b1, err)
      $display("test errors done");
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1;
      `CHK("shunt rst", 8'hff, shunt_open)
      apb(1'b0, 12'h000, 32'h0);
      `CHK("ctrl rst", 32'h0, rd)
      apb(1'b0, 12'h010, 32'h0);
      `CHK("cfg rst", 32'h0, rd)
      apb(1'b0, 12'h004, 32'h0);
      `CHK("prot rst", 8'h0, rd[7:0])
      $display("test reset done");
      end_of_test();
   end
endmodule : tb
